//--- core/bsid_chain.sv
// boundary scan chain and identification register data path
// Notes on behaviour
// - id register: shift stage plus parallel latch
// - id selected on idcode or test-logic-reset
// - cell 1 enables bit1 and cells 40-45
// - bus bit0 cell 2, own enable 3
// - interrupt cell 14, enable cell 15
// - tx frame sync cell 25, enable 26
// - other cells only observe pins
// - unbonded cell 22 stays in chain
// - id = version,part,manufacturer,1
// - capture loads id, shift-dr shifts out
`timescale 1ns/100ps
`default_nettype none
module bsid_chain
  import bsid_pkg::*;
#(
  parameter logic [10:0] MFR_CODE  = 11'h155, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h1234, // arbitrary value
  parameter logic [3:0]  VER_CODE  = 4'h1     // arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire bsid_tap_t   tap,
  input  wire logic        tdi,
  input  wire logic [45:0] pin_sample,
  output logic             tdo,
  output logic             tdo_oe,
  output bsid_pins_t       pins
);
  // fixed identification code
  localparam logic [31:0] ID_CODE =
    {VER_CODE, PART_CODE, MFR_CODE, 1'b1};

  logic [45:0] chain_r, chain_nxt;   // boundary shift stage
  logic [45:0] latch_r, latch_nxt;   // boundary parallel latch
  logic [31:0] id_r, id_nxt;         // id shift stage
  logic [31:0] idl_r, idl_nxt;       // id parallel latch
  logic        tdo_r, tdo_nxt;       // registered serial output
  logic        oe_r, oe_nxt;
  logic        id_sel;

  // id path also wins during test-logic-reset
  assign id_sel = tap.sel_idcode | tap.test_logic_reset;

  // next state of both data registers
  always_comb begin
    chain_nxt = chain_r;
    latch_nxt = latch_r;
    id_nxt    = id_r;
    idl_nxt   = idl_r;
    tdo_nxt   = tdo_r;
    oe_nxt    = 1'b0;
    if (tap.test_logic_reset) begin
      // hold code in the parallel stage while reset
      idl_nxt = ID_CODE;
    end else if (id_sel) begin
      if (tap.capture_dr) begin
        id_nxt = ID_CODE;
      end else if (tap.shift_dr) begin
        id_nxt = {tdi, id_r[31:1]};
      end
      if (tap.update_dr) begin
        idl_nxt = id_r;
      end
    end else if (tap.sel_boundary) begin
      if (tap.capture_dr) begin
        // every cell captures its pin, including the unbonded one
        chain_nxt = pin_sample;
      end else if (tap.shift_dr) begin
        // cell 0 leaves first toward tdo
        chain_nxt = {tdi, chain_r[45:1]};
      end
      if (tap.update_dr) begin
        latch_nxt = chain_r;
      end
    end
    // output lsb of selected path; updated on each shift
    if (tap.shift_dr) begin
      oe_nxt  = id_sel | tap.sel_boundary;
      tdo_nxt = id_sel ? id_r[0] : chain_r[0];
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chain_r <= CHAIN_RST;
      latch_r <= CHAIN_RST;
      id_r    <= ID_RST;
      idl_r   <= ID_RST;
      tdo_r   <= 1'b0;
      oe_r    <= 1'b0;
    end else begin
      chain_r <= chain_nxt;
      latch_r <= latch_nxt;
      id_r    <= id_nxt;
      idl_r   <= idl_nxt;
      tdo_r   <= tdo_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign tdo    = tdo_r;
  assign tdo_oe = oe_r;

  // pins driven only under extest; enables from control cells
  always_comb begin
    pins.upper_out = {latch_r[CELL_UPPER_LO +: 6],
                      latch_r[CELL_BUS_BIT1]};
    pins.upper_oe  = tap.extest & latch_r[CELL_UPPER_EN];
    pins.bit0_out  = latch_r[CELL_BUS_BIT0];
    pins.bit0_oe   = tap.extest & latch_r[CELL_BIT0_EN];
    pins.irq_out   = latch_r[CELL_IRQ];
    pins.irq_oe    = tap.extest & latch_r[CELL_IRQ_EN];
    pins.sync_out  = latch_r[CELL_SYNC];
    pins.sync_oe   = tap.extest & latch_r[CELL_SYNC_EN];
  end
endmodule : bsid_chain
`default_nettype wire

//--- core/bsid_pkg.sv
// package for the boundary scan chain and identification register block
package bsid_pkg;
  // chain geometry
  localparam int unsigned CHAIN_LEN     = 46;
  localparam int unsigned ID_LEN        = 32;
  // control and data cell positions
  localparam int unsigned CELL_BUS_BIT1 = 0;
  localparam int unsigned CELL_UPPER_EN = 1;
  localparam int unsigned CELL_BUS_BIT0 = 2;
  localparam int unsigned CELL_BIT0_EN  = 3;
  localparam int unsigned CELL_IRQ      = 14;
  localparam int unsigned CELL_IRQ_EN   = 15;
  localparam int unsigned CELL_SYNC     = 25;
  localparam int unsigned CELL_SYNC_EN  = 26;
  localparam int unsigned CELL_UNBONDED = 22;
  localparam int unsigned CELL_UPPER_LO = 40;
  // identification code field widths
  localparam int unsigned MFR_W         = 11;
  localparam int unsigned PART_W        = 16;
  localparam int unsigned VER_W         = 4;
  // reset values
  localparam logic [45:0] CHAIN_RST     = 46'h0;
  localparam logic [31:0] ID_RST        = 32'h0;

  // tap state decoded by the controller outside this block
  typedef struct packed {
    logic test_logic_reset;   // controller in test-logic-reset
    logic capture_dr;         // capture-dr state
    logic shift_dr;           // shift-dr state
    logic update_dr;          // update-dr state
    logic sel_idcode;         // identification instruction current
    logic sel_boundary;       // sample/preload or extest current
    logic extest;             // extest current: pins driven from latches
  } bsid_tap_t;

  // pin drive for the four driven pin groups
  typedef struct packed {
    logic [6:0] upper_out;    // bus bits 1..7
    logic       upper_oe;
    logic       bit0_out;
    logic       bit0_oe;
    logic       irq_out;
    logic       irq_oe;
    logic       sync_out;
    logic       sync_oe;
  } bsid_pins_t;
endpackage : bsid_pkg

//--- sim/bsid_chain_asserts.sv
// checker for the chain and identification data path ports
`timescale 1ns/100ps
`default_nettype none
module bsid_chain_asserts
  import bsid_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire bsid_tap_t   tap,
  input wire logic [45:0] pin_sample,
  input wire logic        tdo,
  input wire bsid_pins_t  pins
);
  logic [45:0] p1, p2, p3; // pin history, so no $past is taken of a slice
  always_ff @(posedge ref_clk) {p3, p2, p1} <= {p2, p1, pin_sample};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence bcap; tap.capture_dr && tap.sel_boundary; endsequence
  sequence bsh; tap.shift_dr && tap.sel_boundary; endsequence
  sequence bupd; bcap ##1 tap.update_dr ##1 tap.extest; endsequence
  a_id_lsb_one: assert property (tap.capture_dr && tap.sel_idcode ##1
    tap.shift_dr |=> tdo) else $error("id lsb not one");
  a_cell0_first: assert property (bcap ##1 bsh |=> tdo == p2[0])
    else $error("cell 0 not first out");
  a_cell1_next: assert property (bcap ##1 bsh[*2] |=> tdo == p3[1])
    else $error("cell 1 not second out");
  a_no_drive: assert property (!tap.extest |-> !(pins.upper_oe ||
    pins.bit0_oe || pins.irq_oe || pins.sync_oe)) else $error("pin driven");
  a_upper_en: assert property (bupd |-> pins.upper_oe == p2[1] &&
    pins.upper_out[0] == p2[0]) else $error("upper group wrong");
  a_bit0_en: assert property (bupd |-> pins.bit0_oe == p2[3] &&
    pins.bit0_out == p2[2]) else $error("bit0 group wrong");
  a_irq_en: assert property (bupd |-> pins.irq_oe == p2[15] &&
    pins.irq_out == p2[14]) else $error("irq pin wrong");
  a_sync_en: assert property (bupd |-> pins.sync_oe == p2[26] &&
    pins.sync_out == p2[25]) else $error("sync pin wrong");
  c_id: cover property (tap.capture_dr && tap.sel_idcode ##1 tap.shift_dr);
  c_bshift: cover property (bcap ##1 bsh[*2]);
  c_extest: cover property (bupd);
endmodule : bsid_chain_asserts
bind bsid_chain bsid_chain_asserts u_chk (.ref_clk, .sys_rst, .tap,
  .pin_sample, .tdo, .pins);
`default_nettype wire

//--- sim/bsid_chain_tb_top.sv
// testbench top for the chain and identification data path
`timescale 1ns/100ps
`default_nettype none
module bsid_chain_tb_top
  import bsid_pkg::*;
;
  localparam logic [10:0] MFR  = 11'h2B7;  // arbitrary value
  localparam logic [15:0] PART = 16'h5A3C; // arbitrary value
  localparam logic [3:0]  VER  = 4'hA;     // arbitrary value
  logic        ref_clk, sys_rst, tdi, tdo, tdo_oe;
  logic [45:0] pin_sample;
  logic [63:0] r, d;
  bsid_tap_t   tap;
  bsid_pins_t  pins;
  int          fail_count = 0, cmp_count = 0;
  bsid_chain #(.MFR_CODE(MFR), .PART_CODE(PART), .VER_CODE(VER)) dut (
    .ref_clk, .sys_rst, .tap, .tdi, .pin_sample, .tdo, .tdo_oe, .pins);
  bsid_ctl ctl (.ref_clk, .tdo, .tap, .tdi);
  task automatic check(input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // watchdog: run needs well under 10 us
  initial begin
    #100us fail_count++;
    close_out();
  end
  initial begin
    sys_rst = 1'b1;
    pin_sample = '0;
    void'($urandom(32'h0d87));
    repeat (6) @(posedge ref_clk);
    #2 sys_rst = 1'b0;
    // 33 shifts: the code, then the first bit shifted in
    r = {$urandom, $urandom};
    ctl.scan(1'b1, 1'b0, 33, r, d);
    check(64'(d[32:0]), 64'({r[0], VER, PART, MFR, 1'b1}));
    // 47 shifts: 46 cells with the unbonded one, then tdi
    repeat (4) begin
      pin_sample = 46'({$urandom, $urandom});
      r = {$urandom, $urandom};
      ctl.scan(1'b0, 1'b0, 47, r, d);
      check(64'(d[46:0]), 64'({r[0], pin_sample}));
    end
    // capture straight into the latches, pins driven under extest
    for (int k = 0; k < 2; k++) begin
      pin_sample = k ? 46'h3FFF_FFFF_FFFF : '0;
      ctl.scan(1'b0, 1'b1, 0, r, d);
      check(64'({pins.upper_oe, pins.bit0_oe, pins.irq_oe, pins.sync_oe}),
            k ? 64'hF : 64'h0);
    end
    close_out();
  end
endmodule : bsid_chain_tb_top
`default_nettype wire

//--- sim/bsid_ctl.sv
// test controller model: drives tap levels and serial data
`timescale 1ns/100ps
`default_nettype none
module bsid_ctl
  import bsid_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic tdo,
  output var bsid_tap_t tap,
  output var logic  tdi
);
  initial begin
    tap = '0;
    tdi = 1'b0;
  end
  // capture, n shifts, update; reads tdo 2 ns after each shift edge
  task automatic scan(input logic id, ext, input int n,
                      input logic [63:0] din, output logic [63:0] dout);
    dout = '0;
    tap = '0;
    tap.sel_idcode = id;
    tap.sel_boundary = !id;
    tap.extest = ext;
    tap.capture_dr = 1'b1;
    @(posedge ref_clk);
    #2 tap.capture_dr = 1'b0;
    tap.shift_dr = n > 0;
    for (int i = 0; i < n; i++) begin
      tdi = din[i];
      @(posedge ref_clk);
      #2 dout[i] = tdo;
    end
    tap.shift_dr = 1'b0;
    tap.update_dr = 1'b1;
    @(posedge ref_clk);
    #2 tap.update_dr = 1'b0;
    tdi = ~tdi; // inverted last bit, not a stale copy
  endtask : scan
endmodule : bsid_ctl
`default_nettype wire
